// [include/pssc_pkg.sv]
// shared constants, types and state layout of the pipelined sync sram control block
// Function
// - A selected, ungated edge with advance-or-load low loads the external address, read-write high means read, and data moves two cycles later.
// - The chip is selected only with both active-low selects low and the active-high select high.
// - A deselected load edge starts no access and leaves the data bus undriven two cycles later.
// - Advance-or-load high after a load or burst steps the burst counter and repeats the same access type on the internal address.
// - Read-write is ignored on advance edges, so the burst type is the one chosen at the load.
// - Advance-or-load high after a deselect or no-op is a no-op with the bus undriven in its data phase.
// - An edge with the edge gate high is ignored, so the pipeline, burst and data pin registers keep their state and only the hold flag is set.
// - The data outputs are undriven from reset until a read drives them.
// - Each active-low lane strobe covers one nine-bit lane of eight data bits plus one extra bit.
// - A write updates exactly the lanes whose strobes are low, none when all are high, and reads ignore strobes.
// - The narrow build has only lanes one and two and their strobes.
// - With burst order high the two low address bits are the start value xor a count of 0 to 3.
// - With burst order low the two low address bits are the start value plus the count modulo four.
// - After the fourth address the counter wraps to the start value and keeps counting.
package pssc_pkg;

	localparam int MAX_ADDR_W = 19;
	localparam int DEF_ADDR_W = 18;
	localparam int MAX_LANES = 4;
	localparam int NARROW_LANES = 2;
	localparam int BYTE_BITS = 8;
	localparam int LANE_BITS = 9;
	localparam int EXTRA_POS = 8;
	localparam int DATA_PHASE_CYCLES = 2;
	localparam int BURST_LEN = 4;
	localparam int CNT_W = 2;
	localparam int FIFO_DEPTH = 32;
	localparam int MAX_DATA_W = MAX_LANES * LANE_BITS;
	localparam logic OE_RESET = 1'b0;
	localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;

	// kind of access a pipeline stage carries
	typedef enum logic [1:0] {OP_NONE, OP_WR, OP_RD} pssc_op_e;

	// one sampled command as it walks the pipeline
	typedef struct packed {
		pssc_op_e op;
		logic [MAX_ADDR_W-1:0] addr;
		logic [MAX_LANES-1:0] strobe_n;
	} pssc_cmd_s;

	// one committed write as it leaves through the fifo
	typedef struct packed {
		logic [MAX_ADDR_W-1:0] addr;
		logic [MAX_DATA_W-1:0] data;
		logic [MAX_LANES-1:0] mask;
	} pssc_wr_s;

	// whole state of the control core
	typedef struct packed {
		pssc_cmd_s s1;
		pssc_cmd_s s2;
		pssc_op_e burstOp;
		logic [CNT_W-1:0] base;
		logic [CNT_W-1:0] cnt;
		logic rdEn;
		logic [MAX_ADDR_W-1:0] rdAddr;
		logic [MAX_DATA_W-1:0] dq;
		logic oe;
		logic hold;
	} pssc_core_s;

	localparam pssc_cmd_s CMD_RESET = '{op: OP_NONE, addr: '0, strobe_n: '1};

endpackage : pssc_pkg

// [logic/pssc_burst_addr.sv]
// two-bit burst address generator, interleaved or linear
`timescale 1ns/1ps
module pssc_burst_addr (
	input wire logic [1:0] base, // low bits at load
	input wire logic [1:0] count, // steps since load
	input wire logic interleaved, // burst order select level
	output logic [1:0] low // low address bits for this step
);

	// two-bit arithmetic gives the wrap after the fourth address for free
	always_comb begin
		if (interleaved) begin
			low = base ^ count;
		end else begin
			low = 2'(base + count);
		end
	end

endmodule : pssc_burst_addr

// [logic/pssc_fifo.sv]
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module pssc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = pssc_pkg::FIFO_DEPTH
) (
	input wire logic clk, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic inValid, // word offered
	output logic inReady, // room for a word
	input wire logic [WIDTH-1:0] inData, // offered word
	output logic outValid, // word available
	input wire logic outReady, // drain side takes it
	output logic [WIDTH-1:0] outData // oldest word
);

	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_chk
		$error("fifo depth must be a power of two of at least two");
	end

	typedef struct packed {
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
		logic outValid;
		logic inReady;
	} pssc_fifo_s;

	pssc_fifo_s r;
	pssc_fifo_s n;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// flags come from flops so both sides see clean levels
	always_comb begin
		n = r;
		push = inValid & r.inReady;
		pop = r.outValid & outReady;
		n.wp = PW'(r.wp + PW'(push));
		n.rp = PW'(r.rp + PW'(pop));
		n.cnt = (PW+1)'(r.cnt + (PW+1)'(push) - (PW+1)'(pop));
		n.outValid = n.cnt != '0;
		n.inReady = n.cnt != (PW+1)'(DEPTH);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '{wp: '0, rp: '0, cnt: '0, outValid: 1'b0, inReady: 1'b1};
		end else begin
			r <= n;
		end
	end

	// storage needs no reset, only written words are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[r.wp] <= inData;
		end
	end

	assign inReady = r.inReady;
	assign outValid = r.outValid;
	assign outData = mem[r.rp];

endmodule : pssc_fifo

// [logic/pssc_sram_ctrl.sv]
// control core of the pipelined sync sram: decode, burst, data pipeline, write fifo
`timescale 1ns/1ps
module pssc_sram_ctrl #(
	parameter int LANES = pssc_pkg::MAX_LANES,
	parameter int ADDR_W = pssc_pkg::DEF_ADDR_W,
	parameter int FIFO_DEPTH = pssc_pkg::FIFO_DEPTH
) (
	input wire logic clk, // core clock, 200 MHz
	input wire logic rstn, // async reset, active low
	input wire logic edgeGate_n, // low lets the edge act
	input wire logic selectA_n, // first select, active low
	input wire logic selectB, // select, active high
	input wire logic selectC_n, // second select, active low
	input wire logic advanceOrLoad, // high advance, low load
	input wire logic readNotWrite, // high read, low write
	input wire logic [LANES-1:0] laneWriteStrobe_n, // per-lane write strobe
	input wire logic burstOrderSelect, // high interleaved, low linear
	input wire logic [ADDR_W-1:0] addrIn, // external address
	input wire logic [LANES*pssc_pkg::LANE_BITS-1:0] dqIn, // data pins, input side
	output logic [LANES*pssc_pkg::LANE_BITS-1:0] dqOut, // data pins, output side
	output logic dqOe, // high while driving data pins
	output logic memRdEn, // storage read strobe
	output logic [ADDR_W-1:0] memRdAddr, // storage read address
	input wire logic [LANES*pssc_pkg::LANE_BITS-1:0] memRdData, // storage data, within the strobe cycle
	output logic memWrValid, // committed write available
	input wire logic memWrReady, // storage takes the write
	output logic [ADDR_W-1:0] memWrAddr, // committed write address
	output logic [LANES*pssc_pkg::LANE_BITS-1:0] memWrData, // committed write data
	output logic [LANES-1:0] memWrMask, // lanes to update, active high
	output logic holdOut // last edge was blocked
);

	localparam int DW = LANES * pssc_pkg::LANE_BITS;
	localparam int WR_W = $bits(pssc_pkg::pssc_wr_s);

	// the narrow build keeps only two lanes
	if (LANES != pssc_pkg::MAX_LANES && LANES != pssc_pkg::NARROW_LANES) begin : g_lane_chk
		$error("lanes must be four or two");
	end
	if (ADDR_W < 3 || ADDR_W > pssc_pkg::MAX_ADDR_W) begin : g_addr_chk
		$error("address width out of range");
	end

	pssc_pkg::pssc_core_s r;
	pssc_pkg::pssc_core_s n;

	logic selected;
	logic wantPush;
	logic hold;
	logic gateHold;
	logic fullHold;
	logic orderHold;
	logic pushNow;
	logic [1:0] cntNext;
	logic [1:0] lowNext;
	logic [pssc_pkg::MAX_LANES-1:0] strobeWide_n;
	pssc_pkg::pssc_wr_s wrIn;
	pssc_pkg::pssc_wr_s wrOut;
	logic fifoInReady;
	logic fifoOutValid;
	logic [WR_W-1:0] fifoOutData;

	// all three selects must agree
	assign selected = ~selectA_n & ~selectC_n & selectB;

	// absent upper strobes read as inactive
	always_comb begin
		strobeWide_n = '1;
		strobeWide_n[LANES-1:0] = laneWriteStrobe_n;
	end

	// counter step for the next advance, two bits wrap after the fourth address
	assign cntNext = 2'(r.cnt + 2'h1);

	pssc_burst_addr u_burst (
		.base(r.base),
		.count(cntNext),
		.interleaved(burstOrderSelect),
		.low(lowNext)
	);

	// a write data phase with no lane strobe low commits nothing
	assign wantPush = (r.s2.op == pssc_pkg::OP_WR) && (r.s2.strobe_n != '1);

	// committed write: lane mask is the inverted strobes
	always_comb begin
		wrIn = '0;
		wrIn.addr = r.s2.addr;
		wrIn.data = pssc_pkg::MAX_DATA_W'(dqIn);
		wrIn.mask = ~r.s2.strobe_n;
	end

	// the edge is blocked by the gate pin, by a full fifo, or by a read that
	// would overtake a write still queued; the stall keeps the far side in order
	always_comb begin
		gateHold = edgeGate_n;
		fullHold = wantPush && !fifoInReady;
		orderHold = (r.s1.op == pssc_pkg::OP_RD) && (fifoOutValid || wantPush);
		hold = gateHold || fullHold || orderHold;
		// a read stall must still let the write in front of it land,
		// otherwise the two would wait on each other forever
		pushNow = wantPush && !gateHold && !fullHold;
	end

	// next state: one pipeline step per unblocked edge
	always_comb begin
		n = r;
		n.hold = hold;
		// a blocked edge keeps read strobe and address, storage keeps answering;
		// on a read stall the write phase in stage two still completes
		if (hold && pushNow) begin
			n.s2.op = pssc_pkg::OP_NONE;
			n.oe = 1'b0;
		end
		if (!hold) begin
			// stage two takes stage one, so issued phases move as a pair
			n.s2 = r.s1;
			// storage read is launched one edge early to meet the data phase
			n.rdEn = r.s1.op == pssc_pkg::OP_RD;
			n.rdAddr = r.s1.addr;
			// data phase two edges after the command
			n.oe = r.s2.op == pssc_pkg::OP_RD;
			if (r.s2.op == pssc_pkg::OP_RD) begin
				n.dq = pssc_pkg::MAX_DATA_W'(memRdData);
			end
			n.s1 = pssc_pkg::CMD_RESET;
			n.s1.strobe_n = strobeWide_n;
			if (!advanceOrLoad) begin
				if (selected) begin
					// load: external address, direction from read-write
					n.s1.op = readNotWrite ? pssc_pkg::OP_RD : pssc_pkg::OP_WR;
					n.s1.addr = pssc_pkg::MAX_ADDR_W'(addrIn);
					n.burstOp = n.s1.op;
					n.base = addrIn[1:0];
					n.cnt = pssc_pkg::CNT_RESET;
				end else begin
					// deselect or stop: no access, bus released in its phase
					n.burstOp = pssc_pkg::OP_NONE;
					n.cnt = pssc_pkg::CNT_RESET;
				end
			end else if (r.burstOp != pssc_pkg::OP_NONE) begin
				// advance: direction kept from the load, only low bits step
				n.s1.op = r.burstOp;
				n.s1.addr = {r.s1.addr[pssc_pkg::MAX_ADDR_W-1:2], lowNext};
				n.cnt = cntNext;
			end else begin
				n.s1.op = pssc_pkg::OP_NONE;
			end
			// keep the upper address of the burst while advancing
			if (advanceOrLoad && r.burstOp != pssc_pkg::OP_NONE) begin
				n.s1.addr[pssc_pkg::MAX_ADDR_W-1:2] = r.s1.addr[pssc_pkg::MAX_ADDR_W-1:2];
			end
		end
	end

	// whole state in one register; a gated edge changes only its hold flag
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r.s1 <= pssc_pkg::CMD_RESET;
			r.s2 <= pssc_pkg::CMD_RESET;
			r.burstOp <= pssc_pkg::OP_NONE;
			r.base <= pssc_pkg::CNT_RESET;
			r.cnt <= pssc_pkg::CNT_RESET;
			r.rdEn <= 1'b0;
			r.rdAddr <= '0;
			r.dq <= '0;
			r.oe <= pssc_pkg::OE_RESET;
			r.hold <= 1'b0;
		end else begin
			r <= n;
		end
	end

	// committed writes leave in order through the fifo; a slow storage
	// side fills it and then stalls the pins through the hold term
	pssc_fifo #(
		.WIDTH(WR_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.inValid(pushNow),
		.inReady(fifoInReady),
		.inData(wrIn),
		.outValid(fifoOutValid),
		.outReady(memWrReady),
		.outData(fifoOutData)
	);

	assign wrOut = pssc_pkg::pssc_wr_s'(fifoOutData);

	// outputs straight from flops
	assign dqOut = r.dq[DW-1:0];
	assign dqOe = r.oe;
	assign memRdEn = r.rdEn;
	assign memRdAddr = r.rdAddr[ADDR_W-1:0];
	assign memWrValid = fifoOutValid;
	assign memWrAddr = wrOut.addr[ADDR_W-1:0];
	assign memWrData = wrOut.data[DW-1:0];
	assign memWrMask = wrOut.mask[LANES-1:0];
	assign holdOut = r.hold;

endmodule : pssc_sram_ctrl

// [bench/pssc_sram_ctrl_chk.sv]
// concurrent checks on the ports of the sram control core
`timescale 1ns/1ps
module pssc_sram_ctrl_chk #(
	parameter int LANES = 4,
	parameter int ADDR_W = 18
) (
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire logic edgeGate_n, // gate
	input wire logic selectA_n, // select
	input wire logic selectB, // select
	input wire logic selectC_n, // select
	input wire logic advanceOrLoad, // advance
	input wire logic readNotWrite, // direction
	input wire logic [LANES-1:0] laneWriteStrobe_n, // strobes
	input wire logic burstOrderSelect, // order
	input wire logic [ADDR_W-1:0] addrIn, // address
	input wire logic [LANES*9-1:0] dqOut, // data out
	input wire logic dqOe, // driving
	input wire logic memRdEn, // read strobe
	input wire logic [ADDR_W-1:0] memRdAddr, // read address
	input wire logic memWrValid, // write offered
	input wire logic memWrReady, // write taken
	input wire logic [LANES-1:0] memWrMask, // write lanes
	input wire logic holdOut // edge blocked
);
	logic sel, go, ld;
	logic [1:0] aLo;
	logic [ADDR_W-3:0] aHi;
	// decode of each sampled edge; go means last edge taken and this one ungated
	assign sel = !selectA_n && selectB && !selectC_n;
	assign go = !holdOut && !edgeGate_n;
	assign ld = !edgeGate_n && !advanceOrLoad;
	assign aLo = addrIn[1:0];
	assign aHi = addrIn[ADDR_W-1:2];
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	load_read_a: assert property (ld && sel && readNotWrite ##1 go ##1 !holdOut |->
		memRdEn && memRdAddr == $past(addrIn, 2)) else $error("read strobe wrong");
	burst_step_a: assert property (ld && sel && readNotWrite
		##1 go && advanceOrLoad ##1 go ##1 !holdOut |-> memRdEn &&
		memRdAddr[ADDR_W-1:2] == $past(aHi, 3) &&
		memRdAddr[1:0] == ($past(burstOrderSelect, 2) ? $past(aLo, 3) ^ 2'h1 : $past(aLo, 3) + 2'h1))
		else $error("burst address wrong");
	read_drive_a: assert property (memRdEn && !edgeGate_n ##1 !holdOut |-> dqOe)
		else $error("read data not driven");
	first_drive_a: assert property ($rose(dqOe) |-> $past(memRdEn))
		else $error("bus driven without read");
	desel_float_a: assert property (ld && !sel ##1 go ##1 go ##1 !holdOut |-> !dqOe)
		else $error("bus driven after deselect");
	gate_freeze_a: assert property (edgeGate_n |=>
		holdOut && $stable(dqOut) && $stable(dqOe)) else $error("gated edge changed outputs");
	// the pushed word is seen in the cycle after its data phase, before storage can take it
	write_commit_a: assert property (ld && sel && !readNotWrite
		&& laneWriteStrobe_n != '1 ##1 go ##1 go ##1 !holdOut |-> memWrValid)
		else $error("write not committed");
	mask_any_a: assert property (memWrValid |-> memWrMask != '0)
		else $error("empty write committed");
	// main scenarios seen
	rd_burst_c: cover property (ld && sel && readNotWrite ##1 go && advanceOrLoad);
	gate_c: cover property (edgeGate_n ##1 edgeGate_n);
	stall_c: cover property (memWrValid && !memWrReady ##1 !edgeGate_n ##1 holdOut);
endmodule : pssc_sram_ctrl_chk

bind pssc_sram_ctrl pssc_sram_ctrl_chk #(.LANES(LANES), .ADDR_W(ADDR_W)) u_chk (.clk, .rstn,
	.edgeGate_n, .selectA_n, .selectB, .selectC_n, .advanceOrLoad, .readNotWrite, .laneWriteStrobe_n,
	.burstOrderSelect, .addrIn, .dqOut, .dqOe, .memRdEn, .memRdAddr, .memWrValid, .memWrReady,
	.memWrMask, .holdOut);

// [bench/pssc_store_model.sv]
// storage behind the control core, write side can be stalled
`timescale 1ns/1ps
module pssc_store_model (
	input wire logic clk, // clock
	input wire logic stall, // refuse writes
	input wire logic memRdEn, // read strobe
	input wire logic [17:0] memRdAddr, // read address
	output logic [35:0] memRdData, // read data
	input wire logic memWrValid, // write offered
	output logic memWrReady, // write taken
	input wire logic [17:0] memWrAddr, // write address
	input wire logic [35:0] memWrData, // write data
	input wire logic [3:0] memWrMask // write lanes
);
	logic [35:0] mem [logic [17:0]];
	assign memWrReady = !stall;
	// answer within the strobe cycle and hold until the next strobe
	always @(memRdEn or memRdAddr) if (memRdEn) memRdData = mem[memRdAddr];
	// lane merge on each taken word
	always @(posedge clk) begin
		if (memWrValid && memWrReady) for (int i = 0; i < 4; i++) if (memWrMask[i])
			mem[memWrAddr][9*i+:9] = memWrData[9*i+:9];
	end
endmodule : pssc_store_model

// [bench/pssc_sram_ctrl_tb_top.sv]
// self-checking bench for the sram control core
`timescale 1ns/1ps
module pssc_sram_ctrl_tb_top;
	typedef struct packed {logic [1:0] op; logic [17:0] a; logic [3:0] s; logic [35:0] d;} pssc_ph_s;
	logic clk = 0, rstn = 0, edgeGate_n = 0, selectA_n = 1, selectB = 0, selectC_n = 1;
	logic advanceOrLoad = 0, readNotWrite = 1, burstOrderSelect = 0, stall = 0;
	logic holdOut, dqOe, memRdEn, memWrValid, memWrReady;
	logic [3:0] laneWriteStrobe_n = 4'hf, memWrMask;
	logic [17:0] addrIn = 18'h0, memRdAddr, memWrAddr, base;
	logic [35:0] dqIn = 36'h0, dqOut, memRdData, memWrData;
	logic [35:0] expMem [logic [17:0]];
	logic [1:0] cnt, kind;
	logic [7:0] salt = 8'h0;
	pssc_ph_s p1, p2, cur;
	int err_count = 0, total_checks = 0, blocked = 0;
	// rows: adv rnw selA_n selB selC_n order, address, strobes
	localparam logic [27:0] ROWS [28] = '{
		{6'b000101, 18'h00101, 4'h0}, {6'b110101, 18'h3ffff, 4'h0}, {6'b110101, 18'h0, 4'h0},
		{6'b110101, 18'h0, 4'h0}, {6'b110101, 18'h0, 4'h0}, {6'b000100, 18'h2aa12, 4'h0},
		{6'b110100, 18'h0, 4'h0}, {6'b110100, 18'h0, 4'h0}, {6'b110100, 18'h0, 4'h0},
		{6'b011100, 18'h0, 4'h0}, {6'b100100, 18'h0, 4'h0}, {6'b000101, 18'h00101, 4'h5},
		{6'b010101, 18'h00101, 4'hf}, {6'b100101, 18'h0, 4'hf}, {6'b100101, 18'h0, 4'hf},
		{6'b100101, 18'h0, 4'hf}, {6'b100101, 18'h0, 4'hf}, {6'b010000, 18'h0, 4'hf},
		{6'b010100, 18'h2aa13, 4'hf}, {6'b110100, 18'h0, 4'hf}, {6'b110100, 18'h0, 4'hf},
		{6'b110100, 18'h0, 4'hf}, {6'b010110, 18'h0, 4'hf}, {6'b000100, 18'h2aa12, 4'hf},
		{6'b010100, 18'h2aa12, 4'h0}, {6'b011100, 18'h0, 4'h0}, {6'b100100, 18'h0, 4'h0},
		{6'b100100, 18'h0, 4'h0}};
	initial forever #2.5 clk = ~clk;
	pssc_sram_ctrl #(.FIFO_DEPTH(4)) DUT (.clk, .rstn, .edgeGate_n, .selectA_n, .selectB,
		.selectC_n, .advanceOrLoad, .readNotWrite, .laneWriteStrobe_n, .burstOrderSelect, .addrIn,
		.dqIn, .dqOut, .dqOe, .memRdEn, .memRdAddr, .memRdData, .memWrValid, .memWrReady, .memWrAddr,
		.memWrData, .memWrMask, .holdOut);
	pssc_store_model u_store (.clk, .stall, .memRdEn, .memRdAddr, .memRdData, .memWrValid,
		.memWrReady, .memWrAddr, .memWrData, .memWrMask);
	task automatic check(string name, logic [39:0] exp, logic [39:0] got);
		total_checks++;
		if (exp !== got) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// one command; a refused edge is presented again unchanged
	task automatic step(logic [27:0] r);
		int n;
		{advanceOrLoad, readNotWrite, selectA_n, selectB, selectC_n, burstOrderSelect, addrIn,
			laneWriteStrobe_n} = r;
		if (!r[27]) begin
			kind = (!r[25] && r[24] && !r[23]) ? (r[26] ? 2'h2 : 2'h1) : 2'h0;
			base = r[21:4];
			cnt = 2'h0;
		end else if (kind != 2'h0) cnt++;
		salt++;
		cur.op = kind;
		cur.a = {base[17:2], r[22] ? base[1:0] ^ cnt : base[1:0] + cnt};
		cur.s = r[3:0];
		cur.d = {cur.a, ~cur.a} ^ {4{1'b0, salt}};
		dqIn = (p2.op == 2'h1) ? p2.d : ~dqIn; // undriven phase shows a moving pattern
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (holdOut === 1'b1 && n < 60);
		blocked += n - 1;
		check("holdOut", 40'h0, holdOut);
		if (p2.op == 2'h2) check("dqOut", expMem[p2.a], dqOut);
		check("dqOe", p2.op == 2'h2, dqOe);
		if (p2.op == 2'h1) for (int i = 0; i < 4; i++) if (!p2.s[i])
			expMem[p2.a][9*i+:9] = p2.d[9*i+:9];
		p2 = p1;
		p1 = cur;
	endtask : step
	// gated edges must leave dqOut and dqOe alone and raise holdOut
	task automatic suspend(int k);
		logic [39:0] snap;
		snap = {dqOut, dqOe, 1'b1};
		edgeGate_n = 1;
		repeat (k) begin
			@(posedge clk);
			#1;
			check("frozen", snap, {dqOut, dqOe, holdOut});
		end
		edgeGate_n = 0;
	endtask : suspend
	// watchdog, far beyond the hundred or so cycles the run needs
	initial begin
		#20000;
		check("watchdog", 40'h0, 40'h1);
		end_of_test();
	end
	initial begin
		p1 = '0;
		p2 = '0;
		kind = 2'h0;
		repeat (10) @(posedge clk);
		check("reset dqOe", 40'h0, dqOe);
		#1 rstn = 1;
		stall = 1;
		fork
			begin
				repeat (40) @(posedge clk);
				#1 stall = 0;
			end
		join_none
		for (int i = 0; i < 28; i++) begin
			if (i == 15) suspend(3);
			step(ROWS[i]);
		end
		check("refused", 40'h1, blocked > 0);
		step(ROWS[12]);
		rstn = 0;
		@(posedge clk);
		#1;
		check("reset outs", 40'h0, {dqOe, memRdEn, memWrValid, holdOut});
		rstn = 1;
		p1 = '0;
		p2 = '0;
		kind = 2'h0;
		for (int i = 24; i < 28; i++) step(ROWS[i]);
		end_of_test();
	end
endmodule : pssc_sram_ctrl_tb_top
